// >>> hdl/supervisor_defines.vh
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH

// Clock and timebase
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define US_TO_TICKS(us) ((us) * 1000 / `TICK_PERIOD_NS)

// Supervisor intervals in microseconds
`define PGOOD_DELAY_US 300000
`define DEBOUNCE_US 38000
`define OFF_DELAY_US 2300
`define OCP_ARM_US 75000
`define OVOC_FILTER_US 73
`define UV_FILTER_US 150

// Counter widths
`define TIMER_W 20
`define TICK_W 8

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STATUS 12'h008
`define OFF_IRQ_CLEAR 12'h00c
`define OFF_IRQ_ENABLE 12'h010
`define OFF_FAULT_CAUSE 12'h014

// Control fields and reset
`define CTRL_W 3
`define CTRL_OV_EN 0
`define CTRL_OC_EN 1
`define CTRL_UV_EN 2
`define CTRL_RESET 3'h7

// Status fields
`define STATUS_W 6
`define ST_REQ_OFF 0
`define ST_FAULT 1
`define ST_PGOOD 2
`define ST_SHUTDOWN 3
`define ST_OCP_ARMED 4
`define ST_UV_ARMED 5

// Interrupt event fields
`define IRQ_W 4
`define IRQ_FAULT 0
`define IRQ_PG_RISE 1
`define IRQ_PG_FALL 2
`define IRQ_REQ_EDGE 3
`define IRQ_RESET 4'h0

// Fault cause fields
`define CAUSE_W 4
`define CAUSE_OV 0
`define CAUSE_OC 1
`define CAUSE_UV12 2
`define CAUSE_UV35 3

`endif

// >>> hdl/qual_timer.v
`include "supervisor_defines.vh"

// Counts timebase ticks while a condition holds; done once it held LIMIT ticks
module qual_timer #(
	parameter WIDTH = `TIMER_W,
	parameter [WIDTH-1:0] LIMIT = 1
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire tick_i,
	input wire cond_i,
	output wire done_o
);

	reg [WIDTH-1:0] cnt_ff; // Ticks the condition has held
	reg done_ff; // Condition held for the full interval
	reg [WIDTH-1:0] nxt_cnt;
	reg nxt_done;

	// Restart on any break of the condition, saturate at the limit
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		if (!cond_i) begin
			nxt_cnt = {WIDTH{1'b0}};
		end else if (tick_i && (cnt_ff != LIMIT)) begin
			nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
		if (cond_i && (cnt_ff == LIMIT)) begin
			nxt_done = 1'b1;
		end
	end

	// State registers
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= {WIDTH{1'b0}};
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign done_o = done_ff;

endmodule // qual_timer

// >>> hdl/pc_supply_fault_supervisor.v
// Notes on behaviour
// [RL1] Power-good rises after inputs good 300ms
// [RL2] Power-good drops at once on undervoltage
// [RL3] Request input is active low from motherboard
// [RL4] Request high forces shutdown, power-good low
// [RL5] Qualified fault latches shutdown until cleared
// [RL6] Request rising edge or reset clears latch
// [RL7] Both request edges debounced 38ms
// [RL8] Undervoltage protection suppressed during turn-on
// [RL9] 12V undervoltage over 150us latches fault
// [RL10] Overcurrent over 73us latches fault
// [RL11] Overvoltage over 73us latches fault
// [RL12] Sense input low: only overvoltage faults
// [RL13] Power-good only when all conditions clean
// [RL14] 3.3V/5V overcurrent armed 75ms after turn-on
// [RL15] Shutdown rises 2.3ms after debounce at turn-off
// [RL16] All intervals counted on an internal tick
`include "supervisor_defines.vh"

module pc_supply_fault_supervisor #(
	parameter TICK_CYC = `TICK_CYCLES,
	parameter PGOOD_TICKS = `US_TO_TICKS(`PGOOD_DELAY_US),
	parameter DEBOUNCE_TICKS = `US_TO_TICKS(`DEBOUNCE_US),
	parameter OFF_TICKS = `US_TO_TICKS(`OFF_DELAY_US),
	parameter OCP_ARM_TICKS = `US_TO_TICKS(`OCP_ARM_US),
	parameter OVOC_TICKS = `US_TO_TICKS(`OVOC_FILTER_US),
	parameter UV_TICKS = `US_TO_TICKS(`UV_FILTER_US)
) (
	input wire clk_i,
	input wire nrst_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	output wire irq_o,
	// Digitised comparator conditions
	input wire good_sense_in_i,
	input wire supply_on_request_n_i,
	input wire rail33_uv_i,
	input wire rail5_uv_i,
	input wire rail12_uv_i,
	input wire [2:0] rail_ov_i,
	input wire [2:0] rail_oc_i,
	// Open-drain outputs: level and pull-low enable
	output wire shutdown_latch_out_o,
	output wire shutdown_latch_oe_o,
	output wire good_indicate_out_o,
	output wire good_indicate_oe_o
);

	localparam TW = `TIMER_W;

	// Reset synchroniser
	reg rst_meta_ff;
	reg rst_n_ff;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// Internal timebase tick
	reg [`TICK_W-1:0] tick_cnt_ff;
	reg tick_ff;
	always @(posedge clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tick_cnt_ff <= {`TICK_W{1'b0}};
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff == TICK_CYC[`TICK_W-1:0] - 8'h01) begin // see [RL16]
			tick_cnt_ff <= {`TICK_W{1'b0}};
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 8'h01;
			tick_ff <= 1'b0;
		end
	end

	// Control, state and register storage
	reg [`CTRL_W-1:0] ctrl_ff; // Protection enables
	reg req_off_ff; // Debounced request, high means off
	reg fault_ff; // Fault latch
	reg [`CAUSE_W-1:0] cause_ff; // What set the latch
	reg shut_ff; // Shutdown output
	reg pg_ff; // Power-good output
	reg shut_oe_ff; // Shutdown pin pull-low enable
	reg pg_oe_ff; // Power-good pin pull-low enable
	reg [`IRQ_W-1:0] irq_sts_ff; // Sticky events
	reg [`IRQ_W-1:0] irq_en_ff; // Event enables
	reg irq_ff;
	reg [31:0] prdata_ff;
	reg pready_ff;
	reg pslverr_ff;

	// Timer outputs
	wire deb_done;
	wire off_done;
	wire arm_done;
	wire ovoc_ov_done;
	wire ovoc_oc_done;
	wire uv12_done;
	wire uv35_done;
	wire pg_done;

	// Request debounce: new level adopted after holding 38ms
	qual_timer #(.WIDTH(TW), .LIMIT(DEBOUNCE_TICKS[TW-1:0])) u_debounce (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(supply_on_request_n_i != req_off_ff), // see [RL7] [RL3]
		.done_o(deb_done)
	);

	// Turn-off delay after the debounced request goes high
	qual_timer #(.WIDTH(TW), .LIMIT(OFF_TICKS[TW-1:0])) u_off_delay (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(req_off_ff), // see [RL15]
		.done_o(off_done)
	);

	// Turn-on arming: request low with sense input good
	wire on_good = ~req_off_ff & good_sense_in_i;
	qual_timer #(.WIDTH(TW), .LIMIT(OCP_ARM_TICKS[TW-1:0])) u_arm (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(on_good), // see [RL14] [RL8]
		.done_o(arm_done)
	);

	// Raw conditions gated by software enables
	wire ov_any = (|rail_ov_i) & ctrl_ff[`CTRL_OV_EN];
	wire oc12 = rail_oc_i[2];
	wire oc_any = (oc12 | ((|rail_oc_i[1:0]) & arm_done)) & ctrl_ff[`CTRL_OC_EN]; // see [RL14]
	wire uv_armed = arm_done & ctrl_ff[`CTRL_UV_EN]; // see [RL8]
	wire uv35 = rail33_uv_i | rail5_uv_i;

	// Fault filters
	qual_timer #(.WIDTH(TW), .LIMIT(OVOC_TICKS[TW-1:0])) u_ov_filt (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(ov_any), // see [RL11]
		.done_o(ovoc_ov_done)
	);
	qual_timer #(.WIDTH(TW), .LIMIT(OVOC_TICKS[TW-1:0])) u_oc_filt (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(oc_any), // see [RL10]
		.done_o(ovoc_oc_done)
	);
	qual_timer #(.WIDTH(TW), .LIMIT(UV_TICKS[TW-1:0])) u_uv12_filt (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(rail12_uv_i & uv_armed), // see [RL9]
		.done_o(uv12_done)
	);
	qual_timer #(.WIDTH(TW), .LIMIT(UV_TICKS[TW-1:0])) u_uv35_filt (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(uv35 & uv_armed),
		.done_o(uv35_done)
	);

	// Qualified faults per sense input level
	wire fault_ov = ovoc_ov_done & ~req_off_ff; // see [RL12]
	wire fault_oc = ovoc_oc_done & on_good; // see [RL12]
	wire fault_uv12 = uv12_done & on_good;
	wire fault_uv35 = uv35_done & on_good;
	wire fault_set = fault_ov | fault_oc | fault_uv12 | fault_uv35;

	// Power-good qualification and delay
	wire pg_clean = on_good & ~rail33_uv_i & ~rail5_uv_i & ~rail12_uv_i & ~(|rail_ov_i)
		& ~(|rail_oc_i) & ~fault_ff & ~fault_set; // see [RL13]
	qual_timer #(.WIDTH(TW), .LIMIT(PGOOD_TICKS[TW-1:0])) u_pg_delay (
		.clk_i(clk_i), .rst_n_i(rst_n_ff), .tick_i(tick_ff),
		.cond_i(pg_clean), // see [RL1]
		.done_o(pg_done)
	);

	// Request edge events
	wire req_rise = deb_done & supply_on_request_n_i & ~req_off_ff;
	wire req_edge = deb_done;
	wire nxt_pg = pg_clean & pg_done; // see [RL2]
	wire nxt_pg_pin = nxt_pg & ~req_off_ff; // see [RL4]
	// Off timer only raises shutdown; once high it stays while the request is off,
	// so the reset level never dips while the off timer is still counting
	wire nxt_shut = (req_off_ff & (off_done | shut_ff)) | fault_ff | fault_set; // see [RL4] [RL5]

	// Supervisor core state
	always @(posedge clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			req_off_ff <= 1'b1;
			fault_ff <= 1'b0; // see [RL6]
			cause_ff <= {`CAUSE_W{1'b0}};
			shut_ff <= 1'b1;
			pg_ff <= 1'b0;
			// Pins: shutdown released, power-good pulled low
			shut_oe_ff <= 1'b0;
			pg_oe_ff <= 1'b1;
		end else begin
			// Adopt debounced request level
			if (deb_done) begin
				req_off_ff <= supply_on_request_n_i;
			end
			// Latch set wins over the clear
			if (fault_set) begin
				fault_ff <= 1'b1; // see [RL5]
				cause_ff <= cause_ff | {fault_uv35, fault_uv12, fault_oc, fault_ov};
			end else if (req_rise) begin
				fault_ff <= 1'b0; // see [RL6]
				cause_ff <= {`CAUSE_W{1'b0}};
			end
			shut_ff <= nxt_shut;
			// Pin enables from their own flops, inverse of the levels
			shut_oe_ff <= ~nxt_shut;
			pg_ff <= nxt_pg_pin; // see [RL4]
			pg_oe_ff <= ~nxt_pg_pin;
		end
	end

	// APB decode helpers
	wire apb_setup = psel_i & ~penable_i;
	wire apb_wr = psel_i & penable_i & pready_ff & pwrite_i;

	// Address decoder for the error path; the read mux decodes on its own
	function addr_ok;
		input [11:0] a;
		begin
			addr_ok = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_IRQ_STATUS)
				|| (a == `OFF_IRQ_CLEAR) || (a == `OFF_IRQ_ENABLE) || (a == `OFF_FAULT_CAUSE);
		end
	endfunction

	// Live status word
	wire [`STATUS_W-1:0] status_w = {uv_armed, arm_done, shut_ff, pg_ff, fault_ff, req_off_ff};

	// Read mux
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			`OFF_CTRL: begin
				rd_mux[`CTRL_W-1:0] = ctrl_ff;
			end
			`OFF_STATUS: begin
				rd_mux[`STATUS_W-1:0] = status_w;
			end
			`OFF_IRQ_STATUS: begin
				rd_mux[`IRQ_W-1:0] = irq_sts_ff;
			end
			`OFF_IRQ_ENABLE: begin
				rd_mux[`IRQ_W-1:0] = irq_en_ff;
			end
			`OFF_FAULT_CAUSE: begin
				rd_mux[`CAUSE_W-1:0] = cause_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Interrupt events, one cycle each except the request edge, which lasts two cycles
	wire [`IRQ_W-1:0] irq_evt = {req_edge, pg_ff & ~nxt_pg, ~pg_ff & nxt_pg, fault_set & ~fault_ff};
	wire clr_hit = apb_wr && (paddr_i == `OFF_IRQ_CLEAR);
	wire [`IRQ_W-1:0] nxt_irq_sts = (irq_sts_ff & ~(clr_hit ? pwdata_i[`IRQ_W-1:0] : 4'h0))
		| irq_evt;

	// APB slave: one wait-free access phase, data prepared in setup
	always @(posedge clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ctrl_ff <= `CTRL_RESET;
			irq_sts_ff <= `IRQ_RESET;
			irq_en_ff <= `IRQ_RESET;
			irq_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~addr_ok(paddr_i);
			if (apb_setup) begin
				prdata_ff <= pwrite_i ? 32'h0000_0000 : rd_mux;
			end
			if (apb_wr && (paddr_i == `OFF_CTRL)) begin
				ctrl_ff <= pwdata_i[`CTRL_W-1:0];
			end
			if (apb_wr && (paddr_i == `OFF_IRQ_ENABLE)) begin
				irq_en_ff <= pwdata_i[`IRQ_W-1:0];
			end
			irq_sts_ff <= nxt_irq_sts;
			irq_ff <= |(nxt_irq_sts & irq_en_ff);
		end
	end

	assign prdata_o = prdata_ff;
	assign pready_o = pready_ff;
	assign pslverr_o = pslverr_ff;
	assign irq_o = irq_ff;
	assign shutdown_latch_out_o = shut_ff;
	assign shutdown_latch_oe_o = shut_oe_ff;
	assign good_indicate_out_o = pg_ff;
	assign good_indicate_oe_o = pg_oe_ff;

endmodule // pc_supply_fault_supervisor

// >>> verification/psu_side_model.sv
module psu_side_model (
	input wire logic clk_i,
	input wire logic want_on_i,
	input wire logic shutdown_i,
	input wire logic sag_i,
	output logic request_n_o,
	output logic sense_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] up_ff = 4'h0; // Rail rise progress
	// Board asks for rails by pulling low
	assign request_n_o = !want_on_i;
	// Rails ramp only while not shut down and not sagging
	always @(posedge clk_i) begin
		up_ff <= (shutdown_i | sag_i) ? 4'h0 : up_ff + {3'h0, ~&up_ff};
	end
	// Sense is good once the ramp is half done
	assign sense_o = up_ff[3];
endmodule // psu_side_model

// >>> verification/supervisor_chk.sv
module supervisor_chk #(
	parameter int TICK_CYC = 2,
	parameter int PGOOD_TICKS = 20,
	parameter int DEBOUNCE_TICKS = 8,
	parameter int OFF_TICKS = 4,
	parameter int OVOC_TICKS = 3
) (
	input wire clk_i,
	input wire nrst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pready_o,
	input wire pslverr_o,
	input wire good_sense_in_i,
	input wire supply_on_request_n_i,
	input wire rail33_uv_i,
	input wire rail5_uv_i,
	input wire [2:0] rail_ov_i,
	input wire shutdown_latch_out_o,
	input wire shutdown_latch_oe_o,
	input wire good_indicate_out_o,
	input wire good_indicate_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LO_MIN = (DEBOUNCE_TICKS - 2) * TICK_CYC;
	localparam int PG_MIN = (PGOOD_TICKS - 2) * TICK_CYC;
	localparam int OV_MAX = (OVOC_TICKS + 1) * TICK_CYC + 3;
	localparam int OFF_MAX = (DEBOUNCE_TICKS + OFF_TICKS + 2) * TICK_CYC + 6;
	logic [7:0] lo_ff, hi_ff, cl_ff, ov_ff; // Run lengths: request low, high, clean, overvoltage
	wire clean = !supply_on_request_n_i && good_sense_in_i && !rail33_uv_i && !rail5_uv_i;
	// Saturating run counters
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lo_ff <= 8'h0;
			hi_ff <= 8'h0;
			cl_ff <= 8'h0;
			ov_ff <= 8'h0;
		end else begin
			lo_ff <= supply_on_request_n_i ? 8'h0 : lo_ff + {7'h0, ~&lo_ff};
			hi_ff <= !supply_on_request_n_i ? 8'h0 : hi_ff + {7'h0, ~&hi_ff};
			cl_ff <= clean ? cl_ff + {7'h0, ~&cl_ff} : 8'h0;
			ov_ff <= (|rail_ov_i && !supply_on_request_n_i) ? ov_ff + {7'h0, ~&ov_ff} : 8'h0;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	property p_oe_inv;
		shutdown_latch_oe_o != shutdown_latch_out_o && good_indicate_oe_o != good_indicate_out_o;
	endproperty
	a_oe_inv: assert property (p_oe_inv) else $error("pin enable not inverse of level");
	property p_good_on;
		good_indicate_out_o |-> !shutdown_latch_out_o;
	endproperty
	a_good_on: assert property (p_good_on) else $error("good high while shut down");
	property p_pg_drop;
		good_indicate_out_o && (rail33_uv_i || rail5_uv_i || !good_sense_in_i) |-> ##2 !good_indicate_out_o;
	endproperty
	a_pg_drop: assert property (p_pg_drop) else $error("good did not drop");
	property p_pg_delay;
		$rose(good_indicate_out_o) |-> cl_ff >= PG_MIN;
	endproperty
	a_pg_delay: assert property (p_pg_delay) else $error("good rose too early");
	property p_debounce;
		$fell(shutdown_latch_out_o) |-> lo_ff >= LO_MIN;
	endproperty
	a_debounce: assert property (p_debounce) else $error("turn-on not debounced");
	property p_off;
		hi_ff >= OFF_MAX |-> shutdown_latch_out_o && !good_indicate_out_o;
	endproperty
	a_off: assert property (p_off) else $error("request off not obeyed");
	property p_ov;
		ov_ff >= OV_MAX |-> shutdown_latch_out_o;
	endproperty
	a_ov: assert property (p_ov) else $error("overvoltage not latched");
	property p_ready;
		psel_i && !penable_i |=> pready_o ##1 !pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("bus answer not one cycle after setup");
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
endmodule // supervisor_chk
bind pc_supply_fault_supervisor supervisor_chk #(.TICK_CYC(TICK_CYC), .PGOOD_TICKS(PGOOD_TICKS),
	.DEBOUNCE_TICKS(DEBOUNCE_TICKS), .OFF_TICKS(OFF_TICKS), .OVOC_TICKS(OVOC_TICKS)) u_chk (.*);

// >>> verification/pc_supply_fault_supervisor_tb_top.sv
module pc_supply_fault_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, q;
	logic want_on = 0, sag = 0, r33 = 0, r5 = 0, r12 = 0, er;
	logic [2:0] ov = 3'h0, oc = 3'h0;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, irq_o, req_n, sense, sd, sd_oe, gd, gd_oe;
	int fail_count = 0, n_checks = 0, cyc = 0;
	// 200 MHz clock
	initial forever #2.5 clk_i = ~clk_i;
	// Timebase and long delays shortened; fault filters keep their real tick counts,
	// so arming is stretched past the longest filter to show turn-on suppression
	pc_supply_fault_supervisor #(.TICK_CYC(2), .PGOOD_TICKS(20), .DEBOUNCE_TICKS(8),
		.OFF_TICKS(4), .OCP_ARM_TICKS(200)) dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .good_sense_in_i(sense),
		.supply_on_request_n_i(req_n), .rail33_uv_i(r33), .rail5_uv_i(r5), .rail12_uv_i(r12),
		.rail_ov_i(ov), .rail_oc_i(oc), .shutdown_latch_out_o(sd), .shutdown_latch_oe_o(sd_oe),
		.good_indicate_out_o(gd), .good_indicate_oe_o(gd_oe));
	psu_side_model u_psu (.clk_i(clk_i), .want_on_i(want_on), .shutdown_i(sd), .sag_i(sag),
		.request_n_o(req_n), .sense_o(sense));
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until ready is sampled
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		acc(0, a, 32'h0);
		chk(q, exp);
	endtask
	// Bounded wait for good (g=1) or shutdown (g=0) to reach v
	task wfor(input logic g, input logic v);
		repeat (1000) if ((g ? gd : sd) !== v) @(posedge clk_i);
	endtask
	// Shutdown must stay at s for n cycles
	task hold(input int n, input logic s);
		repeat (n) begin
			@(posedge clk_i);
			chk(sd, s);
		end
	endtask
	// Cycle the request off and on, with early faults before arming
	task relaunch;
		want_on <= 0;
		repeat (40) @(posedge clk_i);
		want_on <= 1;
		hold(12, 1);
		wfor(0, 0);
		chk(sd, 0);
		// Held longer than both filters, but all before arming
		{r5, oc[0]} <= 2'h3;
		hold(320, 0);
		{r5, oc[0]} <= 2'h0;
		wfor(1, 1);
		chk(gd, 1);
	endtask
	// Cycle limit
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		nrst_i <= 1;
		repeat (3) @(posedge clk_i);
		chk({sd, gd, sd_oe, gd_oe}, 4'h9);
		rd(12'h000, 32'h7);
		acc(1, 12'h004, 32'h0);
		rd(12'h004, 32'h9);
		rd(12'h00c, 32'h0);
		rd(12'h100, 32'h0);
		chk(er, 1'b1);
		// Short request glitch is ignored
		want_on <= 1;
		hold(10, 1);
		want_on <= 0;
		hold(20, 1);
		// Each fault class latches with its own cause
		for (int i = 0; i < 4; i++) begin
			relaunch();
			ov[0] <= 1'b1;
			hold(3, 0);
			{r33, r12, oc[2], ov[0]} <= 4'h1 << i;
			wfor(0, 1);
			chk({sd, gd}, 2'b10);
			rd(12'h014, 32'h1 << i);
			{r33, r12, oc[2], ov[0]} <= 4'h0;
			hold(10, 1);
		end
		relaunch();
		// Sense drop kills good; only overvoltage may fault
		sag <= 1;
		wfor(1, 0);
		chk({sd, gd}, 2'b00);
		// Held past the overcurrent filter: sense low must still block it
		{r12, oc} <= 4'hf;
		hold(160, 0);
		{r12, oc} <= 4'h0;
		rd(12'h008, 32'hf);
		chk(irq_o, 1'b0);
		acc(1, 12'h010, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		acc(1, 12'h00c, 32'hf);
		rd(12'h008, 32'h0);
		chk(irq_o, 1'b0);
		// Turn-off delays shutdown past the debounce
		want_on <= 0;
		hold(20, 0);
		wfor(0, 1);
		chk({sd, gd}, 2'b10);
		summarize();
	end
endmodule // pc_supply_fault_supervisor_tb_top
